/* File: verilog/seg_page_consts.svh */
// Offsets, field positions, reset values and codes of the translation block
`ifndef SEG_PAGE_CONSTS_SVH
`define SEG_PAGE_CONSTS_SVH
// Register byte offsets
`define REG_CTRL 8'h00
`define REG_GDT_BASE 8'h04
`define REG_LDT_BASE 8'h08
`define REG_PDIR_BASE 8'h0c
`define REG_STATUS 8'h10
`define REG_MASK 8'h14
`define REG_FAULT_ADDR 8'h18
`define REG_FETCH_ADDR 8'h1c
// Control and status bits
`define CTRL_PAGING 0
`define ST_GP 0
`define ST_PF 1
`define ST_DONE 2
`define ST_W 3
// Reset values
`define RESET_FETCH_ADDR 32'hffff_fff0
`define RESET_CODE_BASE 32'hffff_0000
`define RESET_DATA_BASE 32'h0000_0000
`define FLAT_LIMIT 20'hfffff
`define CODE_RST_LIMIT 20'h0ffff
// Selector fields
`define SEL_TI 2
`define SEL_IDX_HI 15
`define SEL_IDX_LO 3
// Descriptor word 1 layout
`define D_LIM_HI 19
`define D_GRAN 20
`define D_CODE 21
`define D_RW 22
`define D_DPL_HI 24
`define D_DPL_LO 23
`define D_PRES 25
`define GRAN_FILL 12'hfff
// Segment slots
`define SEG_CODE 2'h0
`define SEG_DATA 2'h1
`define SEG_STACK 2'h2
`define NUM_SEGS 3
// Page walk fields
`define PG_PRES 0
`define PG_DIR_HI 31
`define PG_DIR_LO 22
`define PG_TBL_HI 21
`define PG_TBL_LO 12
`define PG_OFS_HI 11
`define DESC_WORD2 32'h0000_0004
`endif

/* File: verilog/seg_page_pkg.sv */
// Types shared by the translation block
`default_nettype none
package seg_page_pkg;
   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_DESC0 = 5'h02,
      ST_DESC1 = 5'h04,
      ST_PDE   = 5'h08,
      ST_PTE   = 5'h10
   } walk_state_t;
   typedef enum logic [1:0] {
      FLT_NONE = 2'h0,
      FLT_GP   = 2'h1,
      FLT_PF   = 2'h2
   } fault_t;
endpackage : seg_page_pkg
`default_nettype wire

/* File: verilog/seg_check.sv */
// Segment limit, type and privilege check with linear address sum
`timescale 1ns/1ps
`default_nettype none
`include "seg_page_consts.svh"
module seg_check (
   // Cached descriptor
   input wire logic valid,
   input wire logic [31:0] base,
   input wire logic [19:0] limit,
   input wire logic gran,
   input wire logic code,
   input wire logic rw,
   input wire logic [1:0] dpl,
   input wire logic present,
   // Access
   input wire logic [31:0] offset,
   input wire logic write,
   input wire logic [1:0] cpl,
   // Result
   output logic [31:0] linear,
   output logic gp_fault
);
   logic [31:0] eff_limit;
   logic type_bad;

   always_comb begin
      // Granular limit fills the low page bits, so fffff spans all 4 GBytes
      eff_limit = gran ? {limit, `GRAN_FILL} : {12'h000, limit};
      // Code is never writable; data needs the write bit, code the read bit
      type_bad = code ? (write | ~rw) : (write & ~rw);
      // Every field of the descriptor except the base takes part in the decision
      gp_fault = ~valid | ~present | (offset > eff_limit) | type_bad | (cpl > dpl);
      linear = base + offset;
   end
endmodule : seg_check
`default_nettype wire

/* File: verilog/seg_page_xlate.sv */
// Segment and page translation unit with register port and table walker
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "seg_page_consts.svh"
// How it works
// - Every access passes the segment stage; nothing can switch it off.
// - Paging is a separate enable bit in the control register.
// - Linear address is segment base plus offset.
// - With paging off the linear address goes out unchanged.
// - With paging on, directory then table entry map 4 KByte pages.
// - A non-present directory or table entry aborts with a page fault.
// - After reset the fetch address is ffff_fff0.
// - After reset the data segment base is zero.
// - Offset beyond the segment limit raises a general protection fault.
// - Base zero with a 4 GByte limit never faults on limit.
// - Writes to code segments and other disallowed type uses fault.
// - Descriptor size, rights, privilege, type and base all get used.
// - The selector locates its descriptor inside a descriptor table.
// - Descriptor address is table base plus selector index times eight.
// - Selector bit 2 picks the local table, clear picks the global one.
// - A null selector loaded into code or stack slot faults.
module seg_page_xlate (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Segment slot load
   input wire logic ld_req,
   input wire logic [1:0] ld_seg,
   input wire logic [15:0] ld_sel,
   // Memory access request
   input wire logic acc_req,
   input wire logic [1:0] acc_seg,
   input wire logic [31:0] acc_offset,
   input wire logic acc_write,
   input wire logic [1:0] acc_cpl,
   // Table reads from system memory
   output logic mem_rd,
   output logic [31:0] mem_addr,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   // Result
   output logic busy,
   output logic done,
   output seg_page_pkg::fault_t fault,
   output logic phys_valid,
   output logic phys_write,
   output logic [31:0] phys_addr,
   output logic [31:0] fetch_addr,
   output logic irq
);
   localparam logic [31:0] RST_BASE [`NUM_SEGS] = '{`RESET_CODE_BASE, `RESET_DATA_BASE,
      `RESET_DATA_BASE};
   localparam logic [19:0] RST_LIMIT [`NUM_SEGS] = '{`CODE_RST_LIMIT, `FLAT_LIMIT,
      `FLAT_LIMIT};
   localparam logic [`NUM_SEGS-1:0] RST_CODE = 3'h1;

   // Control registers
   logic paging_r, paging_nxt;
   logic [31:0] gdt_base_r, gdt_base_nxt;
   logic [31:0] ldt_base_r, ldt_base_nxt;
   logic [31:0] pdir_base_r, pdir_base_nxt;
   logic [`ST_W-1:0] status_r, status_nxt;
   logic [`ST_W-1:0] mask_r, mask_nxt;
   logic [31:0] fault_addr_r, fault_addr_nxt;
   logic [31:0] fetch_addr_r, fetch_addr_nxt;
   logic [31:0] reg_rdata_r, reg_rdata_nxt;
   logic irq_r, irq_nxt;

   // Segment slot cache
   logic [31:0] sbase_r [`NUM_SEGS];
   logic [31:0] sbase_nxt [`NUM_SEGS];
   logic [19:0] slimit_r [`NUM_SEGS];
   logic [19:0] slimit_nxt [`NUM_SEGS];
   logic [`NUM_SEGS-1:0] svalid_r, svalid_nxt;
   logic [`NUM_SEGS-1:0] sgran_r, sgran_nxt;
   logic [`NUM_SEGS-1:0] scode_r, scode_nxt;
   logic [`NUM_SEGS-1:0] srw_r, srw_nxt;
   logic [`NUM_SEGS-1:0] spres_r, spres_nxt;
   logic [1:0] sdpl_r [`NUM_SEGS];
   logic [1:0] sdpl_nxt [`NUM_SEGS];

   // Walker
   seg_page_pkg::walk_state_t state_r, state_nxt;
   logic [1:0] seg_r, seg_nxt;
   logic [31:0] lin_r, lin_nxt;
   logic [31:0] tmp_r, tmp_nxt;
   logic wr_r, wr_nxt;
   logic mem_rd_r, mem_rd_nxt;
   logic [31:0] mem_addr_r, mem_addr_nxt;
   logic busy_r, busy_nxt;
   logic done_r, done_nxt;
   seg_page_pkg::fault_t fault_r, fault_nxt;
   logic phys_valid_r, phys_valid_nxt;
   logic phys_write_r, phys_write_nxt;
   logic [31:0] phys_addr_r, phys_addr_nxt;

   logic [31:0] chk_lin;
   logic chk_gp;
   logic [`ST_W-1:0] st_set;
   logic [31:0] tbl_base;
   logic sel_null;

   // Checks act on the slot that the request names
   seg_check u_check (
      .valid(svalid_r[acc_seg]),
      .base(sbase_r[acc_seg]),
      .limit(slimit_r[acc_seg]),
      .gran(sgran_r[acc_seg]),
      .code(scode_r[acc_seg]),
      .rw(srw_r[acc_seg]),
      .dpl(sdpl_r[acc_seg]),
      .present(spres_r[acc_seg]),
      .offset(acc_offset),
      .write(acc_write),
      .cpl(acc_cpl),
      .linear(chk_lin),
      .gp_fault(chk_gp)
   );

   // Register port
   always_comb begin
      paging_nxt = paging_r;
      gdt_base_nxt = gdt_base_r;
      ldt_base_nxt = ldt_base_r;
      pdir_base_nxt = pdir_base_r;
      mask_nxt = mask_r;
      fetch_addr_nxt = fetch_addr_r;
      reg_rdata_nxt = 32'h0000_0000;
      if (reg_wr) begin
         case (reg_addr)
            `REG_CTRL: paging_nxt = reg_wdata[`CTRL_PAGING];
            `REG_GDT_BASE: gdt_base_nxt = reg_wdata;
            `REG_LDT_BASE: ldt_base_nxt = reg_wdata;
            `REG_PDIR_BASE: pdir_base_nxt = reg_wdata;
            `REG_MASK: mask_nxt = reg_wdata[`ST_W-1:0];
            default: ;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            `REG_CTRL: reg_rdata_nxt = {31'h0, paging_r};
            `REG_GDT_BASE: reg_rdata_nxt = gdt_base_r;
            `REG_LDT_BASE: reg_rdata_nxt = ldt_base_r;
            `REG_PDIR_BASE: reg_rdata_nxt = pdir_base_r;
            `REG_STATUS: reg_rdata_nxt = {29'h0, status_r};
            `REG_MASK: reg_rdata_nxt = {29'h0, mask_r};
            `REG_FAULT_ADDR: reg_rdata_nxt = fault_addr_r;
            `REG_FETCH_ADDR: reg_rdata_nxt = fetch_addr_r;
            default: reg_rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   // Sticky status; a new event beats a clear in the same cycle
   always_comb begin
      st_set = '0;
      st_set[`ST_DONE] = done_nxt;
      st_set[`ST_GP] = done_nxt && (fault_nxt == seg_page_pkg::FLT_GP);
      st_set[`ST_PF] = done_nxt && (fault_nxt == seg_page_pkg::FLT_PF);
      status_nxt = status_r;
      if (reg_wr && (reg_addr == `REG_STATUS)) begin
         status_nxt = status_r & ~reg_wdata[`ST_W-1:0];
      end
      status_nxt = status_nxt | st_set;
      irq_nxt = |(status_nxt & mask_nxt);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         paging_r <= 1'b0;
         gdt_base_r <= 32'h0000_0000;
         ldt_base_r <= 32'h0000_0000;
         pdir_base_r <= 32'h0000_0000;
         status_r <= '0;
         mask_r <= '0;
         fetch_addr_r <= `RESET_FETCH_ADDR;
         reg_rdata_r <= 32'h0000_0000;
         irq_r <= 1'b0;
      end else begin
         paging_r <= paging_nxt;
         gdt_base_r <= gdt_base_nxt;
         ldt_base_r <= ldt_base_nxt;
         pdir_base_r <= pdir_base_nxt;
         status_r <= status_nxt;
         mask_r <= mask_nxt;
         fetch_addr_r <= fetch_addr_nxt;
         reg_rdata_r <= reg_rdata_nxt;
         irq_r <= irq_nxt;
      end
   end

   // Table walker
   always_comb begin
      state_nxt = state_r;
      seg_nxt = seg_r;
      lin_nxt = lin_r;
      tmp_nxt = tmp_r;
      wr_nxt = wr_r;
      mem_rd_nxt = mem_rd_r;
      mem_addr_nxt = mem_addr_r;
      done_nxt = 1'b0;
      fault_nxt = fault_r;
      phys_valid_nxt = 1'b0;
      phys_write_nxt = phys_write_r;
      phys_addr_nxt = phys_addr_r;
      fault_addr_nxt = fault_addr_r;
      sbase_nxt = sbase_r;
      slimit_nxt = slimit_r;
      sdpl_nxt = sdpl_r;
      svalid_nxt = svalid_r;
      sgran_nxt = sgran_r;
      scode_nxt = scode_r;
      srw_nxt = srw_r;
      spres_nxt = spres_r;
      tbl_base = ld_sel[`SEL_TI] ? ldt_base_r : gdt_base_r;
      sel_null = (ld_sel[`SEL_IDX_HI:`SEL_IDX_LO] == 13'h0) && !ld_sel[`SEL_TI];
      case (state_r)
         seg_page_pkg::ST_IDLE: begin
            if (ld_req) begin
               seg_nxt = ld_seg;
               if (sel_null) begin
                  // Null is legal in the data slot until it is used
                  svalid_nxt[ld_seg] = 1'b0;
                  done_nxt = 1'b1;
                  fault_nxt = (ld_seg == `SEG_DATA) ? seg_page_pkg::FLT_NONE
                     : seg_page_pkg::FLT_GP;
                  fault_addr_nxt = {16'h0000, ld_sel};
               end else begin
                  // Index times eight plus table base
                  mem_addr_nxt = tbl_base + {16'h0000, ld_sel[`SEL_IDX_HI:`SEL_IDX_LO], 3'h0};
                  mem_rd_nxt = 1'b1;
                  state_nxt = seg_page_pkg::ST_DESC0;
               end
            end else if (acc_req) begin
               wr_nxt = acc_write;
               // No bypass exists: the segment check gates every access
               if (chk_gp) begin
                  done_nxt = 1'b1;
                  fault_nxt = seg_page_pkg::FLT_GP;
                  fault_addr_nxt = acc_offset;
               end else if (paging_r) begin
                  lin_nxt = chk_lin;
                  mem_addr_nxt = {pdir_base_r[31:`PG_TBL_LO],
                     chk_lin[`PG_DIR_HI:`PG_DIR_LO], 2'h0};
                  mem_rd_nxt = 1'b1;
                  state_nxt = seg_page_pkg::ST_PDE;
               end else begin
                  done_nxt = 1'b1;
                  fault_nxt = seg_page_pkg::FLT_NONE;
                  phys_valid_nxt = 1'b1;
                  phys_write_nxt = acc_write;
                  phys_addr_nxt = chk_lin;
               end
            end
         end
         seg_page_pkg::ST_DESC0: begin
            if (mem_ack) begin
               tmp_nxt = mem_rdata;
               mem_addr_nxt = mem_addr_r + `DESC_WORD2;
               state_nxt = seg_page_pkg::ST_DESC1;
            end
         end
         seg_page_pkg::ST_DESC1: begin
            if (mem_ack) begin
               // Size, rights, privilege, type and base all cached
               sbase_nxt[seg_r] = tmp_r;
               slimit_nxt[seg_r] = mem_rdata[`D_LIM_HI:0];
               sgran_nxt[seg_r] = mem_rdata[`D_GRAN];
               scode_nxt[seg_r] = mem_rdata[`D_CODE];
               srw_nxt[seg_r] = mem_rdata[`D_RW];
               sdpl_nxt[seg_r] = mem_rdata[`D_DPL_HI:`D_DPL_LO];
               spres_nxt[seg_r] = mem_rdata[`D_PRES];
               svalid_nxt[seg_r] = 1'b1;
               mem_rd_nxt = 1'b0;
               done_nxt = 1'b1;
               fault_nxt = seg_page_pkg::FLT_NONE;
               state_nxt = seg_page_pkg::ST_IDLE;
            end
         end
         seg_page_pkg::ST_PDE: begin
            if (mem_ack) begin
               if (!mem_rdata[`PG_PRES]) begin
                  mem_rd_nxt = 1'b0;
                  done_nxt = 1'b1;
                  fault_nxt = seg_page_pkg::FLT_PF;
                  fault_addr_nxt = lin_r;
                  state_nxt = seg_page_pkg::ST_IDLE;
               end else begin
                  mem_addr_nxt = {mem_rdata[31:`PG_TBL_LO],
                     lin_r[`PG_TBL_HI:`PG_TBL_LO], 2'h0};
                  state_nxt = seg_page_pkg::ST_PTE;
               end
            end
         end
         seg_page_pkg::ST_PTE: begin
            if (mem_ack) begin
               mem_rd_nxt = 1'b0;
               done_nxt = 1'b1;
               state_nxt = seg_page_pkg::ST_IDLE;
               if (!mem_rdata[`PG_PRES]) begin
                  // Access withheld so software can bring the page
                  fault_nxt = seg_page_pkg::FLT_PF;
                  fault_addr_nxt = lin_r;
               end else begin
                  fault_nxt = seg_page_pkg::FLT_NONE;
                  phys_valid_nxt = 1'b1;
                  phys_write_nxt = wr_r;
                  phys_addr_nxt = {mem_rdata[31:`PG_TBL_LO], lin_r[`PG_OFS_HI:0]};
               end
            end
         end
         default: begin
            mem_rd_nxt = 1'b0;
            state_nxt = seg_page_pkg::ST_IDLE;
         end
      endcase
      busy_nxt = (state_nxt != seg_page_pkg::ST_IDLE);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= seg_page_pkg::ST_IDLE;
         seg_r <= `SEG_CODE;
         lin_r <= 32'h0000_0000;
         tmp_r <= 32'h0000_0000;
         wr_r <= 1'b0;
         mem_rd_r <= 1'b0;
         mem_addr_r <= 32'h0000_0000;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         fault_r <= seg_page_pkg::FLT_NONE;
         phys_valid_r <= 1'b0;
         phys_write_r <= 1'b0;
         phys_addr_r <= 32'h0000_0000;
         fault_addr_r <= 32'h0000_0000;
      end else begin
         state_r <= state_nxt;
         seg_r <= seg_nxt;
         lin_r <= lin_nxt;
         tmp_r <= tmp_nxt;
         wr_r <= wr_nxt;
         mem_rd_r <= mem_rd_nxt;
         mem_addr_r <= mem_addr_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
         fault_r <= fault_nxt;
         phys_valid_r <= phys_valid_nxt;
         phys_write_r <= phys_write_nxt;
         phys_addr_r <= phys_addr_nxt;
         fault_addr_r <= fault_addr_nxt;
      end
   end

   // Slot cache; data slot starts flat at base zero
   genvar gi;
   generate
      for (gi = 0; gi < `NUM_SEGS; gi++) begin : g_slot
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               sbase_r[gi] <= RST_BASE[gi];
               slimit_r[gi] <= RST_LIMIT[gi];
               sdpl_r[gi] <= 2'h3;
               svalid_r[gi] <= 1'b1;
               sgran_r[gi] <= ~RST_CODE[gi];
               scode_r[gi] <= RST_CODE[gi];
               srw_r[gi] <= 1'b1;
               spres_r[gi] <= 1'b1;
            end else begin
               sbase_r[gi] <= sbase_nxt[gi];
               slimit_r[gi] <= slimit_nxt[gi];
               sdpl_r[gi] <= sdpl_nxt[gi];
               svalid_r[gi] <= svalid_nxt[gi];
               sgran_r[gi] <= sgran_nxt[gi];
               scode_r[gi] <= scode_nxt[gi];
               srw_r[gi] <= srw_nxt[gi];
               spres_r[gi] <= spres_nxt[gi];
            end
         end
      end
   endgenerate

   assign reg_rdata = reg_rdata_r;
   assign mem_rd = mem_rd_r;
   assign mem_addr = mem_addr_r;
   assign busy = busy_r;
   assign done = done_r;
   assign fault = fault_r;
   assign phys_valid = phys_valid_r;
   assign phys_write = phys_write_r;
   assign phys_addr = phys_addr_r;
   assign fetch_addr = fetch_addr_r;
   assign irq = irq_r;
endmodule : seg_page_xlate
`default_nettype wire

/* File: verification/xlate_checker_sva.sv */
// Concurrent checks on the translation unit's ports
`timescale 1ns/1ps
`default_nettype none
`include "seg_page_consts.svh"
module xlate_checker (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // Requests
   input wire logic ld_req,
   input wire logic [1:0] ld_seg,
   input wire logic [15:0] ld_sel,
   input wire logic acc_req,
   // Table reads
   input wire logic mem_rd,
   input wire logic [31:0] mem_addr,
   input wire logic mem_ack,
   // Result
   input wire logic busy,
   input wire logic done,
   input wire seg_page_pkg::fault_t fault,
   input wire logic phys_valid,
   input wire logic [31:0] fetch_addr
);
   logic paging_r;
   logic [31:0] gdt_r;
   logic [31:0] ldt_r;
   logic [31:0] pdir_r;
   logic [31:0] desc_exp_r;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // Mirror of the table bases, needed to predict walker addresses
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         paging_r <= 1'b0;
         gdt_r <= 32'h0;
         ldt_r <= 32'h0;
         pdir_r <= 32'h0;
      end else if (reg_wr) begin
         if (reg_addr == `REG_CTRL) paging_r <= reg_wdata[`CTRL_PAGING];
         if (reg_addr == `REG_GDT_BASE) gdt_r <= reg_wdata;
         if (reg_addr == `REG_LDT_BASE) ldt_r <= reg_wdata;
         if (reg_addr == `REG_PDIR_BASE) pdir_r <= reg_wdata;
      end
   end

   // Where the descriptor of the selector now on the load port must be
   always_ff @(posedge ref_clk) begin
      desc_exp_r <= (ld_sel[`SEL_TI] ? ldt_r : gdt_r) + {16'h0, ld_sel[15:3], 3'h0};
   end

   sequence s_ld_go;
      ld_req && !busy;
   endsequence
   sequence s_acc_flat;
      acc_req && !busy && !ld_req && !paging_r;
   endsequence
   sequence s_acc_paged;
      acc_req && !busy && !ld_req && paging_r;
   endsequence

   chk_fetch_fixed: assert property (fetch_addr == `RESET_FETCH_ADDR)
      else $error("fetch address left its reset value");
   chk_fetch_read: assert property (reg_rd && reg_addr == `REG_FETCH_ADDR
      |=> reg_rdata == `RESET_FETCH_ADDR)
      else $error("fetch address read back wrong");
   chk_flat_answer: assert property (s_acc_flat |=> done)
      else $error("unpaged access not answered next cycle");
   chk_pv_clean: assert property (phys_valid |-> done && fault == seg_page_pkg::FLT_NONE)
      else $error("memory access issued beside a fault");
   chk_null_fault: assert property (s_ld_go ##0 (ld_sel[15:2] == 14'h0
      && ld_seg != `SEG_DATA) |=> done && fault == seg_page_pkg::FLT_GP)
      else $error("null selector in code or stack slot not faulted");
   chk_desc_addr: assert property (s_ld_go ##0 ld_sel[15:2] != 14'h0
      |=> mem_rd && mem_addr == desc_exp_r)
      else $error("descriptor fetched from wrong address");
   chk_walk_first: assert property (s_acc_paged |=> (mem_rd
      && mem_addr[31:12] == pdir_r[31:12] && mem_addr[1:0] == 2'h0)
      || (done && fault == seg_page_pkg::FLT_GP))
      else $error("walk did not start at the page directory");
   chk_hold_read: assert property (mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr))
      else $error("table read dropped before its answer");
   chk_pf_timing: assert property (done && fault == seg_page_pkg::FLT_PF
      |-> $past(mem_ack) && !phys_valid)
      else $error("page fault not one cycle after a table answer");
endmodule : xlate_checker

bind seg_page_xlate xlate_checker xlate_checker_inst (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .ld_req, .ld_seg, .ld_sel, .acc_req, .mem_rd, .mem_addr, .mem_ack, .busy,
   .done, .fault, .phys_valid, .fetch_addr);
`default_nettype wire

/* File: verification/table_memory.sv */
// System memory model holding descriptor and page tables
`timescale 1ns/1ps
`default_nettype none
module table_memory (
   // Clock
   input wire logic ref_clk,
   // Table read port
   input wire logic rd,
   input wire logic [31:0] addr,
   output logic ack,
   output logic [31:0] rdata,
   // Answer delay in cycles
   input wire logic [3:0] wait_cycles
);
   logic [31:0] words [logic [31:0]];
   logic [3:0] cnt = 4'h0;

   initial begin
      ack = 1'b0;
      rdata = 32'h0;
   end

   // Data toggles between answers so a stale word never passes for a fresh one
   always @(posedge ref_clk) begin
      ack <= 1'b0;
      rdata <= ~rdata;
      if (rd && !ack) begin
         if (cnt >= wait_cycles) begin
            ack <= 1'b1;
            cnt <= 4'h0;
            // Missing entries read as zero, which marks a page not present
            rdata <= words.exists(addr) ? words[addr] : 32'h0;
         end else begin
            cnt <= cnt + 4'h1;
         end
      end
   end
endmodule : table_memory
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the segment and page translation unit
`timescale 1ns/1ps
`default_nettype none
`include "seg_page_consts.svh"
module tb;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, ld_req = 1'b0, acc_req = 1'b0, acc_write = 1'b0;
   logic [1:0] ld_seg = 2'h0, acc_seg = 2'h0, acc_cpl = 2'h0;
   logic [15:0] ld_sel = 16'h0;
   logic [31:0] acc_offset = 32'h0;
   logic [3:0] wait_cycles = 4'h0;
   logic mem_rd, mem_ack, busy, done, phys_valid, phys_write, irq;
   logic [31:0] reg_rdata, mem_addr, mem_rdata, phys_addr, fetch_addr;
   seg_page_pkg::fault_t fault;
   int failures = 0, checks = 0, cycles = 0;

   seg_page_xlate seg_page_xlate_inst (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .ld_req, .ld_seg, .ld_sel, .acc_req, .acc_seg, .acc_offset, .acc_write, .acc_cpl,
      .mem_rd, .mem_addr, .mem_ack, .mem_rdata, .busy, .done, .fault, .phys_valid, .phys_write,
      .phys_addr, .fetch_addr, .irq);
   table_memory table_memory_inst (.ref_clk, .rd(mem_rd), .addr(mem_addr), .ack(mem_ack),
      .rdata(mem_rdata), .wait_cycles);

   initial begin
      forever #50 ref_clk = ~ref_clk;
   end

   task close_out;
      if (failures == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : close_out

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         close_out();
      end
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask : reg_write

   task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      check("reg_rdata", reg_rdata, exp);
   endtask : reg_read

   // One load or access; ep is the first table address of a load, or the physical address
   task automatic run(input logic is_ld, input logic [1:0] seg, input logic [31:0] val,
         input logic wr, input logic [1:0] cpl, input logic [1:0] ef, input logic [31:0] ep);
      int n;
      logic [31:0] first;
      n = 0;
      first = 32'h0;
      ld_req <= is_ld;
      acc_req <= !is_ld;
      ld_seg <= seg;
      acc_seg <= seg;
      ld_sel <= val[15:0];
      acc_offset <= val;
      acc_write <= wr;
      acc_cpl <= cpl;
      @(posedge ref_clk);
      ld_req <= 1'b0;
      acc_req <= 1'b0;
      do begin
         @(posedge ref_clk);
         n++;
         if (mem_rd === 1'b1 && n == 1) first = mem_addr;
      end while (done !== 1'b1 && n < 60);
      check("done", done, 32'h1);
      check("fault", fault, ef);
      check("busy", busy, 32'h0);
      if (is_ld) begin
         if (ep != 32'h0) check("desc_addr", first, ep);
      end else begin
         check("phys_valid", phys_valid, ef == 2'h0);
         if (ef == 2'h0) check("phys_addr", phys_addr, ep);
         if (ef == 2'h0) check("phys_write", phys_write, wr);
      end
   endtask : run

   initial begin
      table_memory_inst.words[32'h1008] = 32'h0001_0000;
      table_memory_inst.words[32'h100c] = 32'h03d0_0001;
      table_memory_inst.words[32'h2010] = 32'h0002_0000;
      table_memory_inst.words[32'h2014] = 32'h0260_00ff;
      table_memory_inst.words[32'h3000] = 32'h0000_4001;
      table_memory_inst.words[32'h4040] = 32'h0005_6001;
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      check("fetch_addr", fetch_addr, 32'hffff_fff0);
      reg_write(`REG_FETCH_ADDR, 32'h0);
      reg_read(`REG_FETCH_ADDR, 32'hffff_fff0);
      reg_read(8'h20, 32'h0);
      reg_write(`REG_GDT_BASE, 32'h1000);
      reg_write(`REG_LDT_BASE, 32'h2000);
      run(1'h0, `SEG_DATA, 32'h1234, 1'h0, 2'h3, 2'h0, 32'h1234);
      run(1'h0, `SEG_DATA, 32'hffff_ffff, 1'h1, 2'h3, 2'h0, 32'hffff_ffff);
      run(1'h0, `SEG_CODE, 32'hffff, 1'h0, 2'h3, 2'h0, 32'hffff_ffff);
      run(1'h0, `SEG_CODE, 32'h1_0000, 1'h0, 2'h3, 2'h1, 32'h0);
      run(1'h0, `SEG_CODE, 32'h10, 1'h1, 2'h3, 2'h1, 32'h0);
      run(1'h1, `SEG_DATA, 32'h8, 1'h0, 2'h0, 2'h0, 32'h1008);
      run(1'h0, `SEG_DATA, 32'h1fff, 1'h1, 2'h3, 2'h0, 32'h1_1fff);
      run(1'h0, `SEG_DATA, 32'h2000, 1'h0, 2'h3, 2'h1, 32'h0);
      run(1'h1, `SEG_CODE, 32'h14, 1'h0, 2'h0, 2'h0, 32'h2010);
      run(1'h0, `SEG_CODE, 32'h10, 1'h0, 2'h0, 2'h0, 32'h2_0010);
      run(1'h0, `SEG_CODE, 32'h10, 1'h0, 2'h3, 2'h1, 32'h0);
      run(1'h0, `SEG_CODE, 32'h10, 1'h1, 2'h0, 2'h1, 32'h0);
      reg_write(`REG_CTRL, 32'h1);
      reg_write(`REG_PDIR_BASE, 32'h3000);
      wait_cycles <= 4'h3;
      run(1'h0, `SEG_DATA, 32'h234, 1'h1, 2'h3, 2'h0, 32'h5_6234);
      run(1'h0, `SEG_DATA, 32'h1234, 1'h0, 2'h3, 2'h2, 32'h0);
      run(1'h0, `SEG_STACK, 32'h40_0000, 1'h1, 2'h3, 2'h2, 32'h0);
      wait_cycles <= 4'h0;
      run(1'h0, `SEG_DATA, 32'h2000, 1'h0, 2'h3, 2'h1, 32'h0);
      reg_read(`REG_STATUS, 32'h7);
      reg_write(`REG_STATUS, 32'h7);
      reg_read(`REG_STATUS, 32'h0);
      reg_write(`REG_MASK, 32'h2);
      @(posedge ref_clk);
      check("irq", irq, 32'h0);
      run(1'h0, `SEG_DATA, 32'h2000, 1'h0, 2'h3, 2'h1, 32'h0);
      check("irq", irq, 32'h0);
      run(1'h0, `SEG_DATA, 32'h1234, 1'h0, 2'h3, 2'h2, 32'h0);
      check("irq", irq, 32'h1);
      reg_write(`REG_STATUS, 32'h2);
      @(posedge ref_clk);
      check("irq", irq, 32'h0);
      run(1'h1, `SEG_STACK, 32'h0, 1'h0, 2'h0, 2'h1, 32'h0);
      run(1'h1, `SEG_CODE, 32'h3, 1'h0, 2'h0, 2'h1, 32'h0);
      run(1'h1, `SEG_DATA, 32'h0, 1'h0, 2'h0, 2'h0, 32'h0);
      run(1'h0, `SEG_DATA, 32'h0, 1'h0, 2'h3, 2'h1, 32'h0);
      close_out();
   end
endmodule : tb
`default_nettype wire
